// >>> dbam_top.v
// dbam_top.v: bank address mux and page-mode strobe sequencer with an
// avalon-mm register slave. assumes the cpu holds mem_req and cpu_address
// until mem_done, and all inputs are synchronous to sys_clk.
//
// Register access over Avalon-MM was left to the implementer.
`timescale 1ns/1ps
`include "dbam_consts.vh"

module dbam_top (
  // clock and reset
  input  wire        sys_clk,
  input  wire        rst_n,
  // avalon-mm slave
  input  wire [7:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  input  wire [3:0]  avs_byteenable,
  output reg  [31:0] avs_readdata,
  output reg         avs_waitrequest,
  output reg  [1:0]  avs_response,
  // cpu memory request
  input  wire        mem_req,
  input  wire [25:0] cpu_address,
  output reg         mem_done,
  output reg         mem_miss,
  // dram pins
  output reg  [11:0] mem_addr_bus,
  output reg  [4:0]  bank_row_strobes_n,
  output reg         col_strobe_n
);

  localparam [2:0] ST_IDLE  = 3'h0;
  localparam [2:0] ST_ROW   = 3'h1;
  localparam [2:0] ST_COL   = 3'h2;
  localparam [2:0] ST_OPEN  = 3'h3;
  localparam [2:0] ST_PRE   = 3'h4;
  localparam [2:0] ST_DONE  = 3'h5;

  // counts are reckoned as integers, then cut to the counter width on purpose
  localparam integer ROW_CYC_I = `DBAM_ROW_SETUP_CYC;
  localparam integer CAS_CYC_I = `DBAM_CAS_PULSE_CYC;
  localparam integer PRE_CYC_I = `DBAM_PRECHARGE_CYC;
  localparam [3:0]   ROW_CYC   = ROW_CYC_I[3:0];
  localparam [3:0]   CAS_CYC   = CAS_CYC_I[3:0];
  localparam [3:0]   PRE_CYC   = PRE_CYC_I[3:0];

  // configuration registers
  reg [7:0] bank_pair01_config;
  reg [7:0] bank_pair23_config;
  reg [7:0] bank4_config;
  reg [7:0] asym_type_select;

  reg [2:0]  state;
  reg [3:0]  cnt;
  reg [2:0]  open_bank;
  reg [14:0] open_row;
  reg        row_open;
  reg [2:0]  cur_bank;

  // per-bank fields
  wire [2:0] sz [0:4];
  wire [4:0] sym_bit;
  assign sz[0] = bank_pair01_config[`DBAM_EVEN_SIZE_HI:`DBAM_EVEN_SIZE_LO];
  assign sz[1] = bank_pair01_config[`DBAM_ODD_SIZE_HI:`DBAM_ODD_SIZE_LO];
  assign sz[2] = bank_pair23_config[`DBAM_EVEN_SIZE_HI:`DBAM_EVEN_SIZE_LO];
  assign sz[3] = bank_pair23_config[`DBAM_ODD_SIZE_HI:`DBAM_ODD_SIZE_LO];
  assign sz[4] = bank4_config[`DBAM_EVEN_SIZE_HI:`DBAM_EVEN_SIZE_LO];
  assign sym_bit = {bank4_config[`DBAM_EVEN_ASYM_BIT],
                    bank_pair23_config[`DBAM_ODD_ASYM_BIT],
                    bank_pair23_config[`DBAM_EVEN_ASYM_BIT],
                    bank_pair01_config[`DBAM_ODD_ASYM_BIT],
                    bank_pair01_config[`DBAM_EVEN_ASYM_BIT]};

  wire [4:0] bank_hit;
  wire [2:0] hit_index;
  wire       hit_valid;

  dbam_bank_decode u_decode (
    .bank_sizes  ({sz[4], sz[3], sz[2], sz[1], sz[0]}),
    .cpu_address (cpu_address),
    .bank_hit    (bank_hit),
    .hit_index   (hit_index),
    .hit_valid   (hit_valid)
  );

  // mapping follows the bank chosen for this cycle
  wire [2:0]  map_bank = (state == ST_IDLE || state == ST_OPEN) ? hit_index : cur_bank;
  wire [11:0] row_addr;
  wire [11:0] col_addr;

  dbam_addr_map u_map (
    .cpu_address (cpu_address),
    .bank_size   (sz[map_bank]),
    .bank_asym   (sym_bit[map_bank]),
    .asym_type   (asym_type_select[map_bank]),
    .row_addr    (row_addr),
    .col_addr    (col_addr)
  );

  wire [14:0] req_row  = cpu_address[`DBAM_ROW_TAG_HI:`DBAM_ROW_TAG_LO];
  wire        page_hit = row_open && (open_bank == hit_index) && (open_row == req_row);

  // strobe sequencer
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state              <= ST_IDLE;
      cnt                <= 4'h0;
      open_bank          <= 3'h0;
      open_row           <= 15'h0000;
      row_open           <= 1'b0;
      cur_bank           <= 3'h0;
      mem_addr_bus       <= 12'h000;
      bank_row_strobes_n <= 5'h1f;
      col_strobe_n       <= 1'b1;
      mem_done           <= 1'b0;
      mem_miss           <= 1'b0;
    end else begin
      mem_done <= 1'b0;
      mem_miss <= 1'b0;
      case (state)
        ST_IDLE, ST_OPEN: begin
          if (mem_req) begin
            if (!hit_valid) begin
              // uninstalled region: no strobe, answer at once
              mem_done <= 1'b1;
              mem_miss <= 1'b1;
              state    <= ST_DONE;
            end else if (page_hit) begin
              // page hit keeps the row strobe, only a fresh column
              mem_addr_bus <= col_addr;
              col_strobe_n <= 1'b0;
              cur_bank     <= hit_index;
              cnt          <= CAS_CYC;
              state        <= ST_COL;
            end else if (row_open) begin
              // another row or bank: close first, cas is shared
              bank_row_strobes_n <= 5'h1f;
              row_open           <= 1'b0;
              cnt                <= PRE_CYC;
              state              <= ST_PRE;
            end else begin
              // row phase first
              mem_addr_bus       <= row_addr;
              cur_bank           <= hit_index;
              bank_row_strobes_n <= ~bank_hit;
              open_bank          <= hit_index;
              open_row           <= req_row;
              row_open           <= 1'b1;
              cnt                <= ROW_CYC;
              state              <= ST_ROW;
            end
          end
        end
        ST_ROW: begin
          if (cnt <= 4'h1) begin
            // column phase after the row
            mem_addr_bus <= col_addr;
            col_strobe_n <= 1'b0;
            cnt          <= CAS_CYC;
            state        <= ST_COL;
          end else begin
            cnt <= cnt - 4'h1;
          end
        end
        ST_COL: begin
          if (cnt <= 4'h1) begin
            col_strobe_n <= 1'b1;
            mem_done     <= 1'b1;
            state        <= ST_DONE;
          end else begin
            cnt <= cnt - 4'h1;
          end
        end
        ST_DONE: begin
          // wait for the cpu to drop its request before the next one
          if (!mem_req)
            state <= row_open ? ST_OPEN : ST_IDLE;
        end
        ST_PRE: begin
          if (cnt <= 4'h1)
            state <= ST_IDLE;
          else
            cnt <= cnt - 4'h1;
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // avalon slave: one-cycle waitrequest then answer
  reg        acc_pending;
  wire       acc = (avs_read || avs_write) && !acc_pending;
  wire       known = (avs_address == `DBAM_OFF_PAIR01) || (avs_address == `DBAM_OFF_PAIR23) ||
                     (avs_address == `DBAM_OFF_BANK4) || (avs_address == `DBAM_OFF_ASYM) ||
                     (avs_address == `DBAM_OFF_STATUS);

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      acc_pending        <= 1'b0;
      avs_waitrequest    <= 1'b1;
      avs_readdata       <= 32'h00000000;
      avs_response       <= 2'h0;
      bank_pair01_config <= `DBAM_CFG_RESET;
      bank_pair23_config <= `DBAM_CFG_RESET;
      bank4_config       <= `DBAM_CFG_RESET;
      asym_type_select   <= `DBAM_CFG_RESET;
    end else begin
      avs_waitrequest <= 1'b1;
      acc_pending     <= 1'b0;
      if (acc) begin
        acc_pending     <= 1'b1;
        avs_waitrequest <= 1'b0;
        avs_response    <= known ? 2'h0 : 2'h2;
        avs_readdata    <= 32'h00000000;
        if (avs_read) begin
          case (avs_address)
            `DBAM_OFF_PAIR01: avs_readdata <= {24'h000000, bank_pair01_config};
            `DBAM_OFF_PAIR23: avs_readdata <= {24'h000000, bank_pair23_config};
            `DBAM_OFF_BANK4:  avs_readdata <= {24'h000000, bank4_config};
            `DBAM_OFF_ASYM:   avs_readdata <= {27'h0000000, asym_type_select[4:0]};
            `DBAM_OFF_STATUS: avs_readdata <= {20'h00000, ~bank_row_strobes_n,
                                                row_open, open_bank, state};
            default:          avs_readdata <= 32'h00000000;
          endcase
        end else if (avs_byteenable[0]) begin
          case (avs_address)
            `DBAM_OFF_PAIR01: bank_pair01_config <= avs_writedata[7:0];
            `DBAM_OFF_PAIR23: bank_pair23_config <= avs_writedata[7:0];
            `DBAM_OFF_BANK4:  bank4_config       <= {4'h0, avs_writedata[3:0]};
            `DBAM_OFF_ASYM:   asym_type_select   <= {3'h0, avs_writedata[4:0]};
            default:          asym_type_select   <= asym_type_select;
          endcase
        end
      end
    end
  end

endmodule

// >>> dbam_consts.vh
// dbam_consts.vh: offsets, field positions, encodings and timing counts
// of the bank address mux; included by the design files by bare name.
`ifndef DBAM_CONSTS_VH
`define DBAM_CONSTS_VH

// register offsets (byte addresses on the avalon bus)
`define DBAM_OFF_PAIR01     8'ha8
`define DBAM_OFF_PAIR23     8'ha9
`define DBAM_OFF_BANK4      8'haa
`define DBAM_OFF_ASYM       8'hd3
`define DBAM_OFF_STATUS     8'hb0

// reset values
`define DBAM_CFG_RESET      8'h00

// field positions in the bank configuration registers
`define DBAM_EVEN_SIZE_HI   2
`define DBAM_EVEN_SIZE_LO   0
`define DBAM_EVEN_ASYM_BIT  3
`define DBAM_ODD_SIZE_HI    6
`define DBAM_ODD_SIZE_LO    4
`define DBAM_ODD_ASYM_BIT   7

// size encodings
`define DBAM_SZ_NONE        3'h0
`define DBAM_SZ_1MB         3'h1
`define DBAM_SZ_2MB         3'h2
`define DBAM_SZ_4MB         3'h3
`define DBAM_SZ_8MB         3'h4
`define DBAM_SZ_16MB        3'h5
`define DBAM_SZ_32MB        3'h6
`define DBAM_SZ_64MB        3'h7

// geometry
`define DBAM_NUM_BANKS      5
`define DBAM_MA_WIDTH       12
`define DBAM_CA_WIDTH       26
`define DBAM_ROW_TAG_HI     25
`define DBAM_ROW_TAG_LO     11

// cycle timing in clocks at 20 mhz (50 ns)
`define DBAM_CLK_NS         50
`define DBAM_ROW_SETUP_NS   50
`define DBAM_CAS_PULSE_NS   100
`define DBAM_PRECHARGE_NS   100
`define DBAM_ROW_SETUP_CYC  ((`DBAM_ROW_SETUP_NS + `DBAM_CLK_NS - 1) / `DBAM_CLK_NS)
`define DBAM_CAS_PULSE_CYC  ((`DBAM_CAS_PULSE_NS + `DBAM_CLK_NS - 1) / `DBAM_CLK_NS)
`define DBAM_PRECHARGE_CYC  ((`DBAM_PRECHARGE_NS + `DBAM_CLK_NS - 1) / `DBAM_CLK_NS)

`endif

// >>> dbam_addr_map.v
// dbam_addr_map.v: combinational row and column address mapping.
// assumes cpu_address is a 26-bit byte address, size and type fields as programmed.
`timescale 1ns/1ps
`include "dbam_consts.vh"

module dbam_addr_map (
  // mapping inputs
  input  wire [25:0] cpu_address,
  input  wire [2:0]  bank_size,
  input  wire        bank_asym,
  input  wire        asym_type,
  // mapped phases
  output reg  [11:0] row_addr,
  output wire [11:0] col_addr
);

  // column phase is the same for every mode and size
  assign col_addr = {cpu_address[25], cpu_address[23], cpu_address[21], cpu_address[10:2]};

  // large banks always decode symmetrically
  wire use_asym = bank_asym && (bank_size != `DBAM_SZ_32MB) && (bank_size != `DBAM_SZ_64MB);

  always @* begin
    // symmetric default
    row_addr = {cpu_address[24], cpu_address[22], cpu_address[20], cpu_address[19:11]};
    // undecoded lines still carry their mapped bits, never held
    if (use_asym && !asym_type) begin
      case (bank_size)
        `DBAM_SZ_1MB:  row_addr[11:9] = {cpu_address[24], cpu_address[22], cpu_address[10]};
        `DBAM_SZ_2MB:  row_addr[11:9] = {cpu_address[24], cpu_address[10], cpu_address[20]};
        `DBAM_SZ_4MB:  row_addr[11:9] = {cpu_address[24], cpu_address[21], cpu_address[20]};
        `DBAM_SZ_8MB:  row_addr[11:9] = {cpu_address[21], cpu_address[22], cpu_address[20]};
        `DBAM_SZ_16MB: row_addr[11:9] = {cpu_address[23], cpu_address[22], cpu_address[20]};
        default:       row_addr[11:9] = {cpu_address[24], cpu_address[22], cpu_address[20]};
      endcase
    end else if (use_asym) begin
      case (bank_size)
        `DBAM_SZ_1MB:  row_addr[11:9] = {cpu_address[24], cpu_address[9], cpu_address[10]};
        `DBAM_SZ_2MB:  row_addr[11:9] = {cpu_address[9], cpu_address[10], cpu_address[20]};
        `DBAM_SZ_4MB:  row_addr[11:9] = {cpu_address[10], cpu_address[21], cpu_address[20]};
        `DBAM_SZ_8MB:  row_addr[11:9] = {cpu_address[21], cpu_address[22], cpu_address[20]};
        `DBAM_SZ_16MB: row_addr[11:9] = {cpu_address[23], cpu_address[22], cpu_address[20]};
        default:       row_addr[11:9] = {cpu_address[24], cpu_address[22], cpu_address[20]};
      endcase
    end
  end

endmodule

// >>> dbam_bank_decode.v
// dbam_bank_decode.v: contiguous bank placement and hit decode.
// assumes the five size fields are stable while a cycle is open.
`timescale 1ns/1ps
`include "dbam_consts.vh"

module dbam_bank_decode (
  // configuration
  input  wire [14:0] bank_sizes,
  // lookup
  input  wire [25:0] cpu_address,
  output reg  [4:0]  bank_hit,
  output reg  [2:0]  hit_index,
  output reg         hit_valid
);

  // bank bytes in 1mb units; 000 means not installed
  function [7:0] dbam_size_mb;
    input [2:0] code;
    begin
      if (code == `DBAM_SZ_NONE)
        dbam_size_mb = 8'h00;
      else
        dbam_size_mb = 8'h01 << (code - 3'h1);
    end
  endfunction

  wire [8:0] base [0:5];
  wire [8:0] addr_mb = {1'b0, cpu_address[25:20]};
  assign base[0] = 9'h000;

  genvar g;
  generate
    for (g = 0; g < `DBAM_NUM_BANKS; g = g + 1) begin : g_bank
      // banks packed from bank 0 upward
      assign base[g+1] = base[g] + {1'b0, dbam_size_mb(bank_sizes[3*g+2:3*g])};
    end
  endgenerate

  integer i;
  always @* begin
    bank_hit  = 5'h00;
    hit_index = 3'h0;
    hit_valid = 1'b0;
    for (i = 0; i < `DBAM_NUM_BANKS; i = i + 1) begin
      if (addr_mb >= base[i] && addr_mb < base[i+1] && !hit_valid) begin
        bank_hit[i] = 1'b1;
        hit_index   = i[2:0];
        hit_valid   = 1'b1;
      end
    end
  end

endmodule

// >>> dbam_dram_model.sv
// dbam_dram_model.sv: passive page-mode dram banks; latch row, column and bank.
// assumes registered strobes, so the address bus has settled 1 ns after a fall.
`timescale 1ns/1ps
module dbam_dram_model (
  // dram pins
  input  wire [11:0] mem_addr_bus,
  input  wire [4:0]  bank_row_strobes_n,
  input  wire        col_strobe_n,
  // latched view
  output reg  [11:0] row_q,
  output reg  [11:0] col_q,
  output reg  [4:0]  bank_q
);
  wire all_closed = &bank_row_strobes_n;
  initial begin
    row_q = 12'h000;
    col_q = 12'h000;
    bank_q = 5'h00;
  end
  // row is taken as the first strobe falls; later falls need a full close
  always @(negedge all_closed) begin
    #1;
    row_q = mem_addr_bus;
    bank_q = ~bank_row_strobes_n;
  end
  always @(negedge col_strobe_n) begin
    #1;
    col_q = mem_addr_bus;
  end
endmodule

// >>> dbam_checker.sv
// dbam_checker.sv: port assertions for the bank address mux.
// assumes cpu_address is held while mem_req is high.
`timescale 1ns/1ps
module dbam_checker (
  // clock and reset
  input wire        sys_clk,
  input wire        rst_n,
  // register bus
  input wire [7:0]  avs_address,
  input wire        avs_read,
  input wire        avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0]  avs_byteenable,
  input wire [31:0] avs_readdata,
  input wire        avs_waitrequest,
  input wire [1:0]  avs_response,
  // cpu side
  input wire        mem_req,
  input wire [25:0] cpu_address,
  input wire        mem_done,
  input wire        mem_miss,
  // dram pins
  input wire [11:0] mem_addr_bus,
  input wire [4:0]  bank_row_strobes_n,
  input wire        col_strobe_n
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  chk_one_bank: assert property ($countones(~bank_row_strobes_n) <= 1)
    else $error("two row strobes low");
  chk_bank_switch: assert property ((bank_row_strobes_n != 5'h1f &&
    $past(bank_row_strobes_n) != 5'h1f) |-> $stable(bank_row_strobes_n))
    else $error("bank changed without close");
  chk_col_in_row: assert property (!col_strobe_n |->
    bank_row_strobes_n != 5'h1f && $stable(bank_row_strobes_n))
    else $error("column strobe without steady row");
  chk_col_pulse: assert property ($fell(col_strobe_n) |=> !col_strobe_n ##1 col_strobe_n)
    else $error("column pulse length");
  chk_col_map: assert property ($fell(col_strobe_n) |-> mem_addr_bus ==
    {cpu_address[25], cpu_address[23], cpu_address[21], cpu_address[10:2]})
    else $error("column phase mapping");
  chk_row_map: assert property (($past(&bank_row_strobes_n) && !(&bank_row_strobes_n))
    |-> mem_addr_bus[8:0] == cpu_address[19:11])
    else $error("row phase low lines");
  chk_miss_flag: assert property (mem_miss |-> mem_done && $stable(bank_row_strobes_n))
    else $error("miss not clean");
  chk_done_bound: assert property ($rose(mem_req) |-> ##[1:8] mem_done)
    else $error("access not finished");
  chk_bus_answer: assert property ((avs_read || avs_write) && avs_waitrequest
    |-> ##[1:2] !avs_waitrequest)
    else $error("register access not answered");
endmodule

bind dbam_top dbam_checker u_chk (.sys_clk, .rst_n, .avs_address, .avs_read, .avs_write,
  .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .avs_response, .mem_req,
  .cpu_address, .mem_done, .mem_miss, .mem_addr_bus, .bank_row_strobes_n, .col_strobe_n);

// >>> dbam_tb.sv
// dbam_tb.sv: self-checking bench for the bank address mux.
// assumes dbam_top, the dram model and the checker are compiled alongside.
`timescale 1ns/1ps
module tb;
  typedef struct {logic [7:0] c0, c1, c2; logic [25:0] a; logic [4:0] s; logic m;} dbam_row_t;
  logic        sys_clk, rst_n, avs_read, avs_write, mem_req, miss;
  logic [7:0]  avs_address;
  logic [31:0] avs_writedata, q;
  logic [3:0]  avs_byteenable;
  logic [25:0] cpu_address, a, msk;
  logic [1:0]  r;
  wire  [31:0] avs_readdata;
  wire         avs_waitrequest, mem_done, mem_miss, col_strobe_n;
  wire  [1:0]  avs_response;
  wire  [11:0] mem_addr_bus, row_q, col_q;
  wire  [4:0]  bank_row_strobes_n, bank_q;
  integer      err_total = 0, n_tests = 0, lat, i, s, m;
  dbam_row_t   rows [6] = '{'{8'h21, 8'h00, 8'h00, 26'h00fffff, 5'h1e, 1'b0},
    '{8'h21, 8'h00, 8'h00, 26'h0100000, 5'h1d, 1'b0},
    '{8'h21, 8'h00, 8'h00, 26'h0300000, 5'h1f, 1'b1},
    '{8'h20, 8'h01, 8'h00, 26'h0200000, 5'h1b, 1'b0},
    '{8'h00, 8'h00, 8'h07, 26'h3fffffc, 5'h0f, 1'b0},
    '{8'h00, 8'h00, 8'h00, 26'h0000000, 5'h1f, 1'b1}};

  dbam_top dut (.sys_clk, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .avs_response, .mem_req, .cpu_address,
    .mem_done, .mem_miss, .mem_addr_bus, .bank_row_strobes_n, .col_strobe_n);
  dbam_dram_model ram (.mem_addr_bus, .bank_row_strobes_n, .col_strobe_n, .row_q, .col_q,
    .bank_q);

  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  task chk(input string n, input logic [31:0] v, input logic [31:0] e);
    n_tests++;
    if (v !== e) begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", n, e, v);
    end
  endtask

  task results;
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // hold the request until waitrequest is seen low, then release
  task bus(input [7:0] ad, input w, input [7:0] d, input [3:0] be);
    integer k;
    k = 0;
    @(posedge sys_clk);
    avs_address <= ad;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= {24'h000000, d};
    avs_byteenable <= be;
    do begin
      @(posedge sys_clk);
      k++;
    end while (avs_waitrequest !== 1'b0 && k < 20);
    q = avs_readdata;
    r = avs_response;
    if (k >= 20) err_total++;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  // lat counts edges from the one that raises mem_req to the one that raises mem_done
  task acc(input [25:0] ad);
    lat = 0;
    @(posedge sys_clk);
    mem_req <= 1'b1;
    cpu_address <= ad;
    @(negedge sys_clk);
    while (mem_done !== 1'b1 && lat < 20) begin
      @(negedge sys_clk);
      lat++;
    end
    miss = mem_miss;
    @(posedge sys_clk);
    mem_req <= 1'b0;
    @(posedge sys_clk);
  endtask

  function logic [11:0] erow(input [25:0] x, input [2:0] z, input [1:0] t);
    logic [2:0] h;
    h = {x[24], x[22], x[20]};
    if (t != 0 && z < 6)
      case (z)
        1: h = (t == 1) ? {x[24], x[22], x[10]} : {x[24], x[9], x[10]};
        2: h = (t == 1) ? {x[24], x[10], x[20]} : {x[9], x[10], x[20]};
        3: h = (t == 1) ? {x[24], x[21], x[20]} : {x[10], x[21], x[20]};
        4: h = {x[21], x[22], x[20]};
        5: h = {x[23], x[22], x[20]};
        default: h = {x[24], x[22], x[20]};
      endcase
    return {h, x[19:11]};
  endfunction

  initial begin
    repeat (20000) @(posedge sys_clk);
    err_total++;
    $display("watchdog expired");
    results;
  end

  initial begin
    rst_n = 1'b0;
    mem_req = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 8'h00;
    avs_writedata = 32'h00000000;
    avs_byteenable = 4'hf;
    cpu_address = 26'h0000000;
    repeat (5) @(posedge sys_clk);
    rst_n <= 1'b1;
    bus(8'ha8, 1'b0, 8'h00, 4'hf);
    chk("pair01 reset", q, 32'h0);
    bus(8'hd3, 1'b1, 8'hff, 4'hf);
    bus(8'hd3, 1'b0, 8'h00, 4'hf);
    chk("asym type bits", q, 32'h1f);
    bus(8'haa, 1'b1, 8'hff, 4'hf);
    bus(8'haa, 1'b0, 8'h00, 4'hf);
    chk("bank4 config", q, 32'h0f);
    bus(8'ha9, 1'b1, 8'h55, 4'he);
    bus(8'ha9, 1'b0, 8'h00, 4'hf);
    chk("masked write", q, 32'h0);
    bus(8'hc0, 1'b0, 8'h00, 4'hf);
    chk("unmapped response", r, 2'b10);
    $display("test registers done");
    foreach (rows[j]) begin
      bus(8'ha8, 1'b1, rows[j].c0, 4'hf);
      bus(8'ha9, 1'b1, rows[j].c1, 4'hf);
      bus(8'haa, 1'b1, rows[j].c2, 4'hf);
      acc(rows[j].a);
      chk("miss flag", miss, rows[j].m);
      if (!rows[j].m) chk("open strobe", bank_row_strobes_n, rows[j].s);
    end
    $display("test placement done");
    i = 0;
    for (s = 1; s < 8; s++)
      for (m = 0; m < 3; m++) begin
        bus(8'ha8, 1'b1, {4'h0, m != 0, s[2:0]}, 4'hf);
        bus(8'hd3, 1'b1, {7'h00, m == 2}, 4'hf);
        msk = (26'h0100000 << (s - 1)) - 26'h0000001;
        a = ({i[4:0], 11'h000} ^ 26'h35a5a54) & msk;
        acc(a);
        chk("row phase", row_q, erow(a, s[2:0], m[1:0]));
        chk("col phase", col_q, {a[25], a[23], a[21], a[10:2]});
        i++;
      end
    $display("test mapping done");
    bus(8'ha8, 1'b1, 8'h21, 4'hf);
    acc(26'h0100000);
    chk("bank1 open", bank_q, 5'h02);
    acc(26'h0000100);
    chk("switch latency", lat, 7);
    acc(26'h0000104);
    chk("page latency", lat, 3);
    chk("page kept", bank_row_strobes_n, 5'h1e);
    chk("page column", col_q, 12'h041);
    acc(26'h0300000);
    chk("miss latency", lat, 1);
    chk("miss pulse", miss, 1'b1);
    bus(8'hb0, 1'b0, 8'h00, 4'hf);
    chk("status open bank0", q, 32'h000000c3);
    $display("test page mode done");
    @(posedge sys_clk);
    rst_n <= 1'b0;
    @(negedge sys_clk);
    chk("reset strobes", bank_row_strobes_n, 5'h1f);
    repeat (4) @(posedge sys_clk);
    rst_n <= 1'b1;
    bus(8'ha8, 1'b0, 8'h00, 4'hf);
    chk("pair01 after reset", q, 32'h0);
    acc(26'h0000000);
    chk("no bank installed", miss, 1'b1);
    $display("test reset done");
    results;
  end
endmodule
